// >>> design/vco_overlay.sv
`timescale 1ns/1ps
module vco_overlay
    import vco_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [3:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire logic FIELD_START,
    input wire logic LINE_START,
    input wire logic PAL_DETECTED,
    input wire logic PIXEL_VALID,
    input wire logic CHAR_PIXEL,
    input wire logic MASK_AREA,
    input wire logic GLYPH_FRAME,
    input wire logic GLYPH_FIELD,
    input wire logic GLYPH_MARKER,
    input wire logic MARKER_READER,
    input wire logic REMOTE_OVERLAY_SWITCH,
    output logic OVERLAY_ON,
    output logic KEY_ENABLE,
    output logic KEY_WHITE,
    output logic [5:0] ROW_INDEX,
    output logic [5:0] ROW_LINE,
    output logic ROW_VALID
);

    // Bus slave state: staged settings and the single-cycle answer.
    vco_cfg_t cfg_r, cfg_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic cmd_on, cmd_off;
    logic [31:0] stat_word;

    // Field-synchronous state.
    vco_cfg_t act_r, act_nxt;
    logic pal_r, pal_nxt;
    logic [5:0] row_r, row_nxt;
    logic [5:0] line_r, line_nxt;
    logic valid_r, valid_nxt;

    // Overlay switch and keyer outputs.
    logic sw_prev_r, sw_prev_nxt;
    logic on_r, on_nxt;
    logic key_r, key_nxt;
    logic white_r, white_nxt;

    // Derived geometry of the active field.
    vco_size_t eff_size;
    vco_style_t eff_style;
    logic [5:0] lines_per_row;
    logic [5:0] rows_per_field;
    logic use_pal;
    logic shown;

    // Wishbone classic slave. Ack rises one cycle after the request and
    // drops the next cycle, so each access costs two clocks; unmapped
    // offsets are still acknowledged and read as zero. A write lands at
    // the edge that samples ack high, where the master also retires the
    // cycle, so a cycle abandoned before ack never changes a setting.
    always_comb begin
        logic req;
        logic commit;
        logic [31:0] wmask;
        logic [31:0] ctrl_word;
        req = CYC_I && STB_I && !ack_r;
        commit = CYC_I && STB_I && WE_I && ack_r;
        wmask = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
        ctrl_word = {20'h00000, cfg_r};
        cfg_nxt = cfg_r;
        ack_nxt = req;
        dat_nxt = 32'h00000000;
        cmd_on = 1'b0;
        cmd_off = 1'b0;
        if (commit) begin
            case (ADR_I)
                VCO_OFS_CTRL: begin
                    ctrl_word = (ctrl_word & ~wmask) | (DAT_I & wmask);
                    cfg_nxt = vco_cfg_t'(ctrl_word[VCO_CTRL_WIDTH-1:0]);
                end
                VCO_OFS_CMD: begin
                    cmd_on = SEL_I[0] && DAT_I[VCO_CMD_ON];
                    cmd_off = SEL_I[0] && DAT_I[VCO_CMD_OFF];
                end
                default: begin
                end
            endcase
        end
        if (req && !WE_I) begin
            case (ADR_I)
                VCO_OFS_CTRL: dat_nxt = ctrl_word;
                VCO_OFS_STAT: dat_nxt = stat_word;
                default: dat_nxt = 32'h00000000;
            endcase
        end
    end

    // Register the bus slave state.
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            cfg_r <= vco_cfg_t'(VCO_CTRL_RESET);
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
        end else begin
            cfg_r <= cfg_nxt;
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    // Status word for software. Row position and size come from the
    // active copy, so a read describes the field on screen and never
    // the settings still waiting for the next field start.
    always_comb begin
        stat_word = {21'h000000, valid_r, row_r, act_r.size, pal_r, on_r};
    end

    // Menus force the medium size and white-on-black keying.
    always_comb begin
        eff_size = act_r.menu ? VCO_SIZE_MED : act_r.size;
        eff_style = act_r.menu ? VCO_STY_WOB : act_r.style;
    end

    // Row height and row count follow size and standard. The counts are
    // constants rather than a division, which keeps the path from the
    // active settings to the row compare short.
    always_comb begin
        case (eff_size)
            VCO_SIZE_TINY: begin
                lines_per_row = VCO_LINES_TINY;
                rows_per_field = pal_r ? VCO_ROWS_PAL_TINY
                    : VCO_ROWS_NTSC_TINY;
            end
            VCO_SIZE_MED: begin
                lines_per_row = VCO_LINES_MED;
                rows_per_field = pal_r ? VCO_ROWS_PAL_MED
                    : VCO_ROWS_NTSC_MED;
            end
            default: begin
                // The spare code behaves as the largest size.
                lines_per_row = VCO_LINES_LARGE;
                rows_per_field = pal_r ? VCO_ROWS_PAL_LARGE
                    : VCO_ROWS_NTSC_LARGE;
            end
        endcase
    end

    // Standard choice for the next field.
    always_comb begin
        case (cfg_r.std)
            VCO_STD_NTSC: use_pal = 1'b0;
            VCO_STD_PAL: use_pal = 1'b1;
            default: use_pal = PAL_DETECTED;
        endcase
    end

    // Settings and standard are copied only at a field start, so a field
    // never mixes two configurations; the row walk restarts there too.
    // After the last row the walk parks with ROW_VALID low until the next
    // field start, so lines below the text area can never be keyed.
    always_comb begin
        act_nxt = act_r;
        pal_nxt = pal_r;
        row_nxt = row_r;
        line_nxt = line_r;
        valid_nxt = valid_r;
        if (FIELD_START) begin
            act_nxt = cfg_r;
            pal_nxt = use_pal;
            row_nxt = 6'h00;
            line_nxt = 6'h00;
            valid_nxt = 1'b1;
        end else if (LINE_START && valid_r) begin
            if (line_r == lines_per_row - 6'h01) begin
                line_nxt = 6'h00;
                row_nxt = row_r + 6'h01;
                valid_nxt = (row_r + 6'h01) < rows_per_field;
            end else begin
                line_nxt = line_r + 6'h01;
            end
        end
    end

    // Register the field-synchronous state.
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            act_r <= vco_cfg_t'(VCO_CTRL_RESET);
            pal_r <= 1'b0;
            row_r <= 6'h00;
            line_r <= 6'h00;
            valid_r <= 1'b0;
        end else begin
            act_r <= act_nxt;
            pal_r <= pal_nxt;
            row_r <= row_nxt;
            line_r <= line_nxt;
            valid_r <= valid_nxt;
        end
    end

    // Remote edges win over a software command in the same cycle, since
    // the contact is the operator's most direct control. A command that
    // meets an edge is dropped, not delayed, so software must reissue it.
    always_comb begin
        sw_prev_nxt = REMOTE_OVERLAY_SWITCH;
        on_nxt = on_r;
        if (sw_prev_r && !REMOTE_OVERLAY_SWITCH) begin
            on_nxt = 1'b1;
        end else if (!sw_prev_r && REMOTE_OVERLAY_SWITCH) begin
            on_nxt = 1'b0;
        end else if (cmd_on) begin
            on_nxt = 1'b1;
        end else if (cmd_off) begin
            on_nxt = 1'b0;
        end
    end

    // Decide whether the current glyph may be drawn at all.
    always_comb begin
        logic kie;
        kie = MARKER_READER ? act_r.kie1 : act_r.kie0;
        shown = 1'b1;
        if (GLYPH_FRAME && !act_r.frames) begin
            shown = 1'b0;
        end
        if (GLYPH_FIELD && (!act_r.frames || !act_r.fields)) begin
            shown = 1'b0;
        end
        if (GLYPH_MARKER && (!act_r.markers || kie)) begin
            shown = 1'b0;
        end
    end

    // Keyer: a hidden glyph falls back to background, so the mask stays
    // solid where it would have been drawn.
    always_comb begin
        logic ink;
        logic masked;
        ink = CHAR_PIXEL && shown;
        masked = (eff_style == VCO_STY_WOB) || (eff_style == VCO_STY_BOW);
        key_nxt = 1'b0;
        white_nxt = white_r;
        if (on_r && valid_r && PIXEL_VALID) begin
            case (eff_style)
                VCO_STY_WHITE: begin
                    key_nxt = ink;
                    white_nxt = 1'b1;
                end
                VCO_STY_WOB: begin
                    key_nxt = ink || MASK_AREA;
                    white_nxt = ink;
                end
                VCO_STY_BLACK: begin
                    key_nxt = ink;
                    white_nxt = 1'b0;
                end
                VCO_STY_BOW: begin
                    key_nxt = ink || MASK_AREA;
                    white_nxt = !ink;
                end
                default: begin
                    // Not reachable with a two-bit style; it keys bare ink
                    // only, so a future code can never paint a stray mask.
                    key_nxt = ink && !masked;
                end
            endcase
        end
    end

    // Register the switch and keyer state.
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            // Matches the idle level of the contact, so leaving reset
            // with the contact open makes no false edge.
            sw_prev_r <= 1'b1;
            on_r <= 1'b0;
            key_r <= 1'b0;
            white_r <= 1'b0;
        end else begin
            sw_prev_r <= sw_prev_nxt;
            on_r <= on_nxt;
            key_r <= key_nxt;
            white_r <= white_nxt;
        end
    end

    // Every output is a flip-flop.
    assign DAT_O = dat_r;
    assign ACK_O = ack_r;
    assign OVERLAY_ON = on_r;
    assign KEY_ENABLE = key_r;
    assign KEY_WHITE = white_r;
    assign ROW_INDEX = row_r;
    assign ROW_LINE = line_r;
    assign ROW_VALID = valid_r;

endmodule : vco_overlay

// >>> shared/vco_pkg.sv
package vco_pkg;

    // Register byte offsets on the Wishbone slave.
    localparam logic [3:0] VCO_OFS_CTRL = 4'h0;
    localparam logic [3:0] VCO_OFS_CMD = 4'h4;
    localparam logic [3:0] VCO_OFS_STAT = 4'h8;

    // Control register field positions.
    localparam int VCO_CTRL_SIZE_LO = 0;
    localparam int VCO_CTRL_STYLE_LO = 2;
    localparam int VCO_CTRL_FRAMES = 4;
    localparam int VCO_CTRL_FIELDS = 5;
    localparam int VCO_CTRL_MARKERS = 6;
    localparam int VCO_CTRL_STD_LO = 7;
    localparam int VCO_CTRL_MENU = 9;
    localparam int VCO_CTRL_KIE0 = 10;
    localparam int VCO_CTRL_KIE1 = 11;
    localparam int VCO_CTRL_WIDTH = 12;
    localparam logic [11:0] VCO_CTRL_RESET = 12'h070;

    // Command register bits.
    localparam int VCO_CMD_ON = 0;
    localparam int VCO_CMD_OFF = 1;

    // Row geometry per size code.
    localparam logic [5:0] VCO_LINES_TINY = 6'h08;
    localparam logic [5:0] VCO_LINES_MED = 6'h10;
    localparam logic [5:0] VCO_LINES_LARGE = 6'h20;
    localparam logic [5:0] VCO_ROWS_NTSC_TINY = 6'h1C;
    localparam logic [5:0] VCO_ROWS_PAL_TINY = 6'h20;
    localparam logic [5:0] VCO_ROWS_NTSC_MED = 6'h0E;
    localparam logic [5:0] VCO_ROWS_PAL_MED = 6'h10;
    localparam logic [5:0] VCO_ROWS_NTSC_LARGE = 6'h07;
    localparam logic [5:0] VCO_ROWS_PAL_LARGE = 6'h08;

    typedef enum logic [1:0] {
        VCO_SIZE_TINY, VCO_SIZE_MED, VCO_SIZE_LARGE, VCO_SIZE_RSVD
    } vco_size_t;

    typedef enum logic [1:0] {
        VCO_STY_WHITE, VCO_STY_WOB, VCO_STY_BLACK, VCO_STY_BOW
    } vco_style_t;

    typedef enum logic [1:0] {
        VCO_STD_AUTO, VCO_STD_NTSC, VCO_STD_PAL, VCO_STD_AUTO2
    } vco_std_t;

    // Display settings as one carrier, both for the staged and active copy.
    typedef struct packed {
        logic kie1;
        logic kie0;
        logic menu;
        vco_std_t std;
        logic markers;
        logic fields;
        logic frames;
        vco_style_t style;
        vco_size_t size;
    } vco_cfg_t;

endpackage : vco_pkg

// >>> sim/vco_overlay_monitor.sv
`timescale 1ns/1ps
module vco_overlay_monitor (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic [31:0] DAT_O,
    input wire logic ACK_O,
    input wire logic FIELD_START,
    input wire logic LINE_START,
    input wire logic PIXEL_VALID,
    input wire logic REMOTE_OVERLAY_SWITCH,
    input wire logic OVERLAY_ON,
    input wire logic KEY_ENABLE,
    input wire logic [5:0] ROW_INDEX,
    input wire logic [5:0] ROW_LINE,
    input wire logic ROW_VALID
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RESET);

    // Bus answers come one cycle after the request and last one cycle.
    a_ack_answer: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("bus request not answered in one cycle");
    a_ack_pulse: assert property (ACK_O |=> !ACK_O)
        else $error("ack held longer than one cycle");
    a_dat_idle: assert property (!ACK_O |-> DAT_O == 32'h0)
        else $error("read data not zero outside ack");
    // The remote contact switches the overlay by edge direction.
    a_remote_on: assert property (
        $fell(REMOTE_OVERLAY_SWITCH) |=> OVERLAY_ON)
        else $error("falling remote edge did not turn overlay on");
    a_remote_off: assert property (
        $rose(REMOTE_OVERLAY_SWITCH) |=> !OVERLAY_ON)
        else $error("rising remote edge did not turn overlay off");
    // No pixel slot means nothing may be keyed.
    a_key_idle: assert property (!PIXEL_VALID |=> !KEY_ENABLE)
        else $error("key raised without a pixel slot");
    // A field restarts the row counting from the top.
    a_row_restart: assert property (FIELD_START |=>
        ROW_INDEX == 6'h00 && ROW_LINE == 6'h00 && ROW_VALID)
        else $error("field start did not restart rows");
    // Every row has at least eight lines, so early lines simply step.
    a_line_step: assert property (
        ROW_VALID && LINE_START && !FIELD_START && ROW_LINE < 6'h07
        |=> ROW_LINE == $past(ROW_LINE) + 6'h01)
        else $error("line within row did not step");
    a_line_hold: assert property (!LINE_START && !FIELD_START |=>
        $stable(ROW_LINE) && $stable(ROW_INDEX))
        else $error("row position moved without a line start");
    a_row_bound: assert property (ROW_VALID |-> ROW_INDEX < 6'h20)
        else $error("valid row beyond largest row count");
endmodule : vco_overlay_monitor

bind vco_overlay vco_overlay_monitor u_mon (.CLOCK(CLOCK), .RESET(RESET),
    .CYC_I(CYC_I), .STB_I(STB_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .FIELD_START(FIELD_START), .LINE_START(LINE_START),
    .PIXEL_VALID(PIXEL_VALID),
    .REMOTE_OVERLAY_SWITCH(REMOTE_OVERLAY_SWITCH),
    .OVERLAY_ON(OVERLAY_ON), .KEY_ENABLE(KEY_ENABLE),
    .ROW_INDEX(ROW_INDEX), .ROW_LINE(ROW_LINE), .ROW_VALID(ROW_VALID));

// >>> sim/vco_video_src.sv
`timescale 1ns/1ps
module vco_video_src (
    input wire logic clk,
    input wire logic rst,
    input wire logic pal_sel,
    input wire logic remote_level,
    output logic field_start,
    output logic line_start,
    output logic pal_detected,
    output logic remote_switch
);
    logic [10:0] cnt_r;

    // Four clocks a line and 300 lines a field, so every size runs out of
    // rows before the next field; field and line pulses never coincide.
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= 11'h000;
            field_start <= 1'h0;
            line_start <= 1'h0;
            pal_detected <= 1'h0;
            remote_switch <= 1'h1;
        end else begin
            cnt_r <= (cnt_r == 11'h4AF) ? 11'h000 : cnt_r + 11'h001;
            field_start <= cnt_r == 11'h002;
            line_start <= cnt_r[1:0] == 2'h0;
            pal_detected <= pal_sel;
            remote_switch <= remote_level;
        end
    end
endmodule : vco_video_src

// >>> sim/vco_overlay_tb.sv
`timescale 1ns/1ps
module vco_overlay_tb;
    import vco_pkg::*;
    logic CLOCK = 1'h0, RESET = 1'h1, CYC_I = 1'h0, STB_I = 1'h0;
    logic WE_I = 1'h0, PIXEL_VALID = 1'h0, CHAR_PIXEL = 1'h0;
    logic MASK_AREA = 1'h0, GLYPH_FRAME = 1'h0, GLYPH_FIELD = 1'h0;
    logic GLYPH_MARKER = 1'h0, MARKER_READER = 1'h0, pal = 1'h0, rem = 1'h1;
    logic [3:0] ADR_I = 4'h0, SEL_I = 4'hF;
    logic [31:0] DAT_I = 32'h0, DAT_O, rd;
    logic ACK_O, FIELD_START, LINE_START, PAL_DETECTED, ROW_VALID;
    logic REMOTE_OVERLAY_SWITCH, OVERLAY_ON, KEY_ENABLE, KEY_WHITE;
    logic [5:0] ROW_INDEX, ROW_LINE, mx;
    int err_count = 0, n_compared = 0, n;
    // Pixel cases: control word, pixel inputs, expected enable and white.
    logic [19:0] pt[20] = '{{12'h070, 6'h20, 2'h3}, {12'h070, 6'h10, 2'h0},
        {12'h074, 6'h20, 2'h3}, {12'h074, 6'h10, 2'h2},
        {12'h078, 6'h20, 2'h2}, {12'h078, 6'h10, 2'h0},
        {12'h07C, 6'h20, 2'h2}, {12'h07C, 6'h10, 2'h3},
        {12'h278, 6'h10, 2'h2}, {12'h278, 6'h20, 2'h3},
        {12'h060, 6'h28, 2'h0}, {12'h060, 6'h24, 2'h0},
        {12'h050, 6'h28, 2'h3}, {12'h050, 6'h24, 2'h0},
        {12'h070, 6'h24, 2'h3}, {12'h030, 6'h22, 2'h0},
        {12'h070, 6'h22, 2'h3}, {12'h470, 6'h22, 2'h0},
        {12'h470, 6'h23, 2'h3}, {12'h870, 6'h23, 2'h0}};
    // Row cases: control word, detected PAL, lines per row, lines per field.
    logic [27:0] rt[9] = '{{12'h0F0, 1'h1, 6'h08, 9'h0E0},
        {12'h170, 1'h0, 6'h08, 9'h100}, {12'h0F1, 1'h0, 6'h10, 9'h0E0},
        {12'h171, 1'h0, 6'h10, 9'h100}, {12'h0F2, 1'h0, 6'h20, 9'h0E0},
        {12'h172, 1'h0, 6'h20, 9'h100}, {12'h070, 1'h1, 6'h08, 9'h100},
        {12'h1F3, 1'h0, 6'h20, 9'h0E0}, {12'h272, 1'h1, 6'h10, 9'h100}};

    vco_overlay u_dut (.CLOCK(CLOCK), .RESET(RESET), .CYC_I(CYC_I),
        .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I),
        .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
        .FIELD_START(FIELD_START), .LINE_START(LINE_START),
        .PAL_DETECTED(PAL_DETECTED), .PIXEL_VALID(PIXEL_VALID),
        .CHAR_PIXEL(CHAR_PIXEL), .MASK_AREA(MASK_AREA),
        .GLYPH_FRAME(GLYPH_FRAME), .GLYPH_FIELD(GLYPH_FIELD),
        .GLYPH_MARKER(GLYPH_MARKER), .MARKER_READER(MARKER_READER),
        .REMOTE_OVERLAY_SWITCH(REMOTE_OVERLAY_SWITCH),
        .OVERLAY_ON(OVERLAY_ON), .KEY_ENABLE(KEY_ENABLE),
        .KEY_WHITE(KEY_WHITE), .ROW_INDEX(ROW_INDEX),
        .ROW_LINE(ROW_LINE), .ROW_VALID(ROW_VALID));
    vco_video_src u_src (.clk(CLOCK), .rst(RESET), .pal_sel(pal),
        .remote_level(rem), .field_start(FIELD_START),
        .line_start(LINE_START), .pal_detected(PAL_DETECTED),
        .remote_switch(REMOTE_OVERLAY_SWITCH));

    always #5 CLOCK = ~CLOCK;

    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One classic cycle; the wait is bounded so a dead slave cannot hang.
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge CLOCK);
        {CYC_I, STB_I, WE_I, ADR_I, DAT_I} <= {2'h3, w, a, d};
        do @(posedge CLOCK); while (ACK_O !== 1'h1 && t++ < 20);
        if (t > 20) err_count++;
        rd = DAT_O;
        {CYC_I, STB_I, WE_I} <= 3'h0;
    endtask : wb

    // Returns just before the edge that takes a field start.
    task fld;
        int t;
        t = 0;
        do begin
            @(posedge CLOCK);
            #1;
        end while (FIELD_START !== 1'h1 && t++ < 3000);
        if (t > 3000) err_count++;
    endtask : fld

    task px(input logic [5:0] p, input logic [1:0] e);
        @(posedge CLOCK);
        {CHAR_PIXEL, MASK_AREA, GLYPH_FRAME, GLYPH_FIELD} <= p[5:2];
        {GLYPH_MARKER, MARKER_READER, PIXEL_VALID} <= {p[1:0], 1'h1};
        @(posedge CLOCK);
        PIXEL_VALID <= 1'h0;
        #1 chk("key_enable", KEY_ENABLE, e[1]);
        if (e[1]) chk("key_white", KEY_WHITE, e[0]);
    endtask : px

    task summarize;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    // Watchdog sized well above the roughly 48000 cycles the tests need.
    initial begin
        repeat (100000) @(posedge CLOCK);
        err_count++;
        summarize();
    end

    initial begin
        repeat (8) @(posedge CLOCK);
        RESET <= 1'h0;
        wb(1'h0, 4'h0, 32'h0);
        chk("ctrl_reset", rd, 32'h070);
        wb(1'h0, 4'hC, 32'h0);
        chk("unmapped", rd, 32'h0);
        wb(1'h1, 4'h4, 32'h1);
        @(posedge CLOCK);
        #1 chk("cmd_on", OVERLAY_ON, 1'h1);
        wb(1'h1, 4'h4, 32'h2);
        @(posedge CLOCK);
        #1 chk("cmd_off", OVERLAY_ON, 1'h0);
        for (int i = 0; i < 3; i++) begin
            @(posedge CLOCK) rem <= i[0];
            repeat (3) @(posedge CLOCK);
            #1 chk("remote", OVERLAY_ON, !i[0]);
        end
        wb(1'h0, 4'h8, 32'h0);
        chk("stat_on", rd[0], 1'h1);
        $display("register and remote test done");
        foreach (pt[i]) begin
            wb(1'h1, 4'h0, {20'h0, pt[i][19:8]});
            fld();
            px(pt[i][7:2], pt[i][1:0]);
        end
        $display("keying table done");
        foreach (rt[i]) begin
            pal <= rt[i][15];
            wb(1'h1, 4'h0, {20'h0, rt[i][27:16]});
            fld();
            fld();
            n = 0;
            mx = 6'h00;
            repeat (2000) begin
                @(posedge CLOCK);
                #1;
                if (ROW_VALID !== 1'h1) break;
                if (LINE_START) n++;
                if (ROW_LINE > mx) mx = ROW_LINE;
            end
            chk("row_lines", mx, rt[i][14:9] - 6'h01);
            chk("field_lines", n, rt[i][8:0]);
        end
        $display("row geometry done");
        wb(1'h1, 4'h0, 32'h070);
        fld();
        wb(1'h1, 4'h0, 32'h078);
        px(6'h20, 2'h3);
        fld();
        px(6'h20, 2'h2);
        $display("field staging done");
        @(posedge CLOCK) rem <= 1'h1;
        RESET <= 1'h1;
        repeat (2) @(posedge CLOCK);
        #1 chk("reset_on", OVERLAY_ON, 1'h0);
        chk("reset_row", ROW_VALID, 1'h0);
        @(posedge CLOCK) RESET <= 1'h0;
        wb(1'h0, 4'h0, 32'h0);
        chk("ctrl_again", rd, 32'h070);
        $display("mid-run reset done");
        summarize();
    end
endmodule : vco_overlay_tb
